// *** core/ten_ops_pkg.sv ***
// Purpose: constants for the 10 Mb/s operations control block
// Assumes: 20 MHz management clock, 16-bit registers
// Notes:   offsets are management register numbers
// Overview of operation
// - Reserved operations bits always read zero
// - Polarity reversed flag, latches high
// - Receive works normally despite reversal
// - Jabber inhibit skips jabber checking
// - Auto polarity inhibit stops pair correction
// - Same control covers 100 Mb/s correction
// - SQE test inhibit suppresses SQE test
// - SQE pulses collision after transmit ends
// - No SQE in full duplex, repeater
// - Auto suppression leaves control bit alone
// - Link loss inhibit forces link passed
// - Squelch inhibit needs data then idle
// - Ext status bit 1 copies remote fault
// - Ext status bit 0 copies link status
// - Latched flags clear on station read
package ten_ops_pkg;
    // Register offsets
    localparam [4:0]      BASIC_STATUS = 5'h01;
    localparam [4:0]      EXT_STATUS   = 5'h11;
    localparam [4:0]      OPERATIONS   = 5'h12;
    // Operations fields
    localparam int        POL_REV_BIT  = 14;
    localparam int        JAB_INH_BIT  = 5;
    localparam int        RSV_ONE_BIT  = 4;
    localparam int        APOL_INH_BIT = 3;
    localparam int        SQE_INH_BIT  = 2;
    localparam int        LLOSS_INH_BIT = 1;
    localparam int        SQL_INH_BIT  = 0;
    localparam [5:0]      CTRL_RESET   = 6'h10;
    // Status fields
    localparam int        BS_RFAULT_BIT = 4;
    localparam int        BS_LINK_BIT  = 2;
    localparam int        ES_RFAULT_BIT = 1;
    localparam int        ES_LINK_BIT  = 0;
    // Timing
    localparam int        CLK_MHZ      = 20;
    localparam int        SQE_DELAY_NS = 1000;
    localparam int        SQE_WIDTH_NS = 1000;
    localparam int        JABBER_US    = 20000;
    localparam int        LINK_LOSS_US = 100000;
    localparam int        SQE_DELAY_CYC = (SQE_DELAY_NS * CLK_MHZ + 999) / 1000;
    localparam int        SQE_WIDTH_CYC = (SQE_WIDTH_NS * CLK_MHZ + 999) / 1000;
    localparam int        JABBER_CYC   = JABBER_US * CLK_MHZ;
    localparam int        LINK_LOSS_CYC = LINK_LOSS_US * CLK_MHZ;
    localparam int        TIMER_W      = 24;
    localparam int        SQE_W        = 6;
    typedef enum logic [1:0] {LINK_FAIL, LINK_WAIT_IDLE, LINK_PASS} link_state_t;
endpackage : ten_ops_pkg

// *** core/pin_sync_if.sv ***
// Purpose: raw pins in, clean levels out
// Assumes: one clock domain on the clean side
// Notes:   width set by the user
`timescale 1ns/1ns
interface pin_sync_if #(parameter int W = 2);
    logic [W-1:0] raw;    // Asynchronous pin levels
    logic [W-1:0] level;  // Filtered levels
    modport sync (input raw, output level);
    modport user (output raw, input level);
endinterface : pin_sync_if

// *** core/pin_sync.sv ***
// Purpose: three-stage pin synchroniser with agreement filter
// Assumes: pins are asynchronous to clk
// Notes:   level only moves once stages two and three agree
`timescale 1ns/1ns
module pin_sync #(
    parameter int W = 2
) (
    input  wire logic clk,      // Management clock
    input  wire logic rst_b,    // Async reset, active low
    pin_sync_if.sync  bus       // Raw in, level out
);
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            logic s1;
            logic s2;
            logic s3;
            logic lvl;
            // First stage feeds only the second, metastability guard
            always_ff @(posedge clk or negedge rst_b) begin
                if (!rst_b) begin
                    s1 <= 1'b0;
                    s2 <= 1'b0;
                    s3 <= 1'b0;
                end else begin
                    s1 <= bus.raw[i];
                    s2 <= s1;
                    s3 <= s2;
                end
            end
            // Move only when stages two and three agree
            always_ff @(posedge clk or negedge rst_b) begin
                if (!rst_b) begin
                    lvl <= 1'b0;
                end else if (s2 == s3) begin
                    lvl <= s3;
                end
            end
            assign bus.level[i] = lvl;
        end
    endgenerate
endmodule : pin_sync

// *** core/ten_mbps_ops_ctrl.sv ***
// Purpose: 10 Mb/s operations control, status and the logic they steer
// Assumes: tx, mode and register inputs on clk
// Notes:   receive pair pins are synchronised here
//
// Our own choice: strobed register access.
`timescale 1ns/1ns
module ten_mbps_ops_ctrl #(
    parameter int JABBER_CYCLES    = ten_ops_pkg::JABBER_CYC,
    parameter int LINK_LOSS_CYCLES = ten_ops_pkg::LINK_LOSS_CYC
) (
    input  wire logic        clk,            // 20 MHz management clock
    input  wire logic        rst_b,          // Async reset, active low
    input  wire logic [4:0]  regAddr,        // Register number
    input  wire logic [15:0] regWrData,      // Write data
    input  wire logic        regWr,          // Write strobe
    input  wire logic        regRd,          // Read strobe
    output logic      [15:0] regRdData,      // Read data, cycle after strobe
    input  wire logic        rxPairPos,      // Receive pair positive pin
    input  wire logic        rxPairNeg,      // Receive pair negative pin
    input  wire logic        txEnable,       // Transmit enable from MAC
    input  wire logic        fullDuplex,     // Full-duplex mode
    input  wire logic        repeaterMode,   // Repeater mode
    input  wire logic        remoteFaultIn,  // Remote fault condition
    output logic             rxData,         // Receive data, polarity fixed
    output logic             rxActive,       // Receive activity
    output logic             collisionOut,   // Collision incl. SQE pulse
    output logic             jabberOut,      // Jabber condition
    output logic             linkUp,         // Link passed
    output logic             polarityFixEn   // Correction applied, 10 and 100
);
    // Control bits held from management writes
    logic                    jabInh;
    logic                    apolInh;
    logic                    sqeInh;
    logic                    llossInh;
    logic                    sqlInh;
    // Synchronised receive pair
    logic                    pos;
    logic                    neg;
    logic                    activeNow;
    logic                    activePrev;
    // Polarity detection and latch
    logic                    polReversed;
    logic                    polLatch;
    // Status latches
    logic                    rfLatch;
    logic                    linkLatch;
    // Link machine and timers
    ten_ops_pkg::link_state_t linkState_reg;
    ten_ops_pkg::link_state_t linkState_next;
    logic [ten_ops_pkg::TIMER_W-1:0] lossCnt;
    logic [ten_ops_pkg::TIMER_W-1:0] jabCnt;
    // SQE sequencing
    logic                    txPrev;
    logic                    sqeAllowed;
    logic                    sqeWait;
    logic                    sqeOn;
    logic [ten_ops_pkg::SQE_W-1:0] sqeCnt;
    // Read decode
    logic                    rdBasic;
    logic                    rdExt;
    logic                    rdOps;
    logic                    wrOps;
    logic [15:0]             rdValue;

    pin_sync_if #(.W(2)) pairBus ();

    assign pairBus.raw = {rxPairNeg, rxPairPos};

    pin_sync #(.W(2)) u_pair_sync (
        .clk   (clk),
        .rst_b (rst_b),
        .bus   (pairBus)
    );

    assign pos = pairBus.level[0];
    assign neg = pairBus.level[1];

    // Register port decode
    assign rdBasic = regRd && (regAddr == ten_ops_pkg::BASIC_STATUS);
    assign rdExt   = regRd && (regAddr == ten_ops_pkg::EXT_STATUS);
    assign rdOps   = regRd && (regAddr == ten_ops_pkg::OPERATIONS);
    assign wrOps   = regWr && (regAddr == ten_ops_pkg::OPERATIONS);

    // Control bits; reserved bits are not stored, so bad writes are harmless
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            jabInh   <= ten_ops_pkg::CTRL_RESET[ten_ops_pkg::JAB_INH_BIT];
            apolInh  <= ten_ops_pkg::CTRL_RESET[ten_ops_pkg::APOL_INH_BIT];
            sqeInh   <= ten_ops_pkg::CTRL_RESET[ten_ops_pkg::SQE_INH_BIT];
            llossInh <= ten_ops_pkg::CTRL_RESET[ten_ops_pkg::LLOSS_INH_BIT];
            sqlInh   <= ten_ops_pkg::CTRL_RESET[ten_ops_pkg::SQL_INH_BIT];
        end else if (wrOps) begin
            jabInh   <= regWrData[ten_ops_pkg::JAB_INH_BIT];
            apolInh  <= regWrData[ten_ops_pkg::APOL_INH_BIT];
            sqeInh   <= regWrData[ten_ops_pkg::SQE_INH_BIT];
            llossInh <= regWrData[ten_ops_pkg::LLOSS_INH_BIT];
            sqlInh   <= regWrData[ten_ops_pkg::SQL_INH_BIT];
        end
    end

    // Activity on either line; its edges mark data and idle
    assign activeNow = pos | neg;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            activePrev <= 1'b0;
        end else begin
            activePrev <= activeNow;
        end
    end

    // Line leading out of idle shows orientation; negative lead is reversed
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            polReversed <= 1'b0;
        end else if (!activePrev && activeNow) begin
            if (neg && !pos) begin
                polReversed <= 1'b1;
            end else if (pos && !neg) begin
                polReversed <= 1'b0;
            end
        end
    end

    // Latched copy; a new reversal beats the read clear
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            polLatch <= 1'b0;
        end else if (polReversed) begin
            polLatch <= 1'b1;
        end else if (rdOps) begin
            polLatch <= 1'b0;
        end
    end

    // Correction enable serves both 10 and 100 Mb/s receive paths
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            polarityFixEn <= 1'b0;
        end else begin
            polarityFixEn <= polReversed && !apolInh;
        end
    end

    // Data always flows; correction only flips its sense
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rxData   <= 1'b0;
            rxActive <= 1'b0;
        end else begin
            rxActive <= activeNow;
            if (polReversed && !apolInh) begin
                rxData <= neg;
            end else begin
                rxData <= pos;
            end
        end
    end

    // Jabber timer saturates, clears when transmit ends
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            jabCnt <= '0;
        end else if (!txEnable || jabInh) begin
            jabCnt <= '0;
        end else if (jabCnt != ten_ops_pkg::TIMER_W'(JABBER_CYCLES)) begin
            jabCnt <= jabCnt + 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            jabberOut <= 1'b0;
        end else begin
            jabberOut <= !jabInh && txEnable &&
                         (jabCnt == ten_ops_pkg::TIMER_W'(JABBER_CYCLES));
        end
    end

    // SQE test is only armed in half-duplex node operation
    assign sqeAllowed = !sqeInh && !fullDuplex && !repeaterMode;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            txPrev <= 1'b0;
        end else begin
            txPrev <= txEnable;
        end
    end

    // Delay, then pulse; a new frame aborts it, collisionOut dropping two cycles after transmit starts
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sqeWait <= 1'b0;
            sqeOn   <= 1'b0;
            sqeCnt  <= '0;
        end else if (txEnable || !sqeAllowed) begin
            sqeWait <= 1'b0;
            sqeOn   <= 1'b0;
            sqeCnt  <= '0;
        end else if (txPrev) begin
            sqeWait <= 1'b1;
            sqeCnt  <= '0;
        end else if (sqeWait) begin
            if (sqeCnt == ten_ops_pkg::SQE_W'(ten_ops_pkg::SQE_DELAY_CYC - 1)) begin
                sqeWait <= 1'b0;
                sqeOn   <= 1'b1;
                sqeCnt  <= '0;
            end else begin
                sqeCnt <= sqeCnt + 1'b1;
            end
        end else if (sqeOn) begin
            if (sqeCnt == ten_ops_pkg::SQE_W'(ten_ops_pkg::SQE_WIDTH_CYC - 1)) begin
                sqeOn  <= 1'b0;
                sqeCnt <= '0;
            end else begin
                sqeCnt <= sqeCnt + 1'b1;
            end
        end
    end

    // Collision carries only the SQE pulse
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            collisionOut <= 1'b0;
        end else begin
            collisionOut <= sqeOn && sqeAllowed;
        end
    end

    // Link loss timer restarts on any receive activity
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            lossCnt <= '0;
        end else if (activeNow || linkState_reg != ten_ops_pkg::LINK_PASS) begin
            lossCnt <= '0;
        end else if (lossCnt != ten_ops_pkg::TIMER_W'(LINK_LOSS_CYCLES)) begin
            lossCnt <= lossCnt + 1'b1;
        end
    end

    // Link integrity machine; squelch inhibit adds a wait for idle
    always_comb begin
        linkState_next = linkState_reg;
        unique case (linkState_reg)
            ten_ops_pkg::LINK_FAIL: begin
                if (activeNow) begin
                    if (sqlInh) begin
                        linkState_next = ten_ops_pkg::LINK_WAIT_IDLE;
                    end else begin
                        linkState_next = ten_ops_pkg::LINK_PASS;
                    end
                end
            end
            ten_ops_pkg::LINK_WAIT_IDLE: begin
                if (activePrev && !activeNow) begin
                    linkState_next = ten_ops_pkg::LINK_PASS;
                end
            end
            ten_ops_pkg::LINK_PASS: begin
                if (lossCnt == ten_ops_pkg::TIMER_W'(LINK_LOSS_CYCLES)) begin
                    linkState_next = ten_ops_pkg::LINK_FAIL;
                end
            end
            default: begin
                linkState_next = ten_ops_pkg::LINK_FAIL;
            end
        endcase
        if (llossInh) begin
            linkState_next = ten_ops_pkg::LINK_PASS;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            linkState_reg <= ten_ops_pkg::LINK_FAIL;
        end else begin
            linkState_reg <= linkState_next;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            linkUp <= 1'b0;
        end else begin
            linkUp <= (linkState_next == ten_ops_pkg::LINK_PASS);
        end
    end

    // Remote fault latches high; either status view's read clears it
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rfLatch <= 1'b0;
        end else if (remoteFaultIn) begin
            rfLatch <= 1'b1;
        end else if (rdBasic || rdExt) begin
            rfLatch <= 1'b0;
        end
    end

    // Link status latches low; a read reloads it from the live link
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            linkLatch <= 1'b0;
        end else if (!linkUp) begin
            linkLatch <= 1'b0;
        end else if (rdBasic || rdExt) begin
            linkLatch <= 1'b1;
        end
    end

    // Read value; reserved operations bits stay zero
    always_comb begin
        rdValue = '0;
        unique case (regAddr)
            ten_ops_pkg::BASIC_STATUS: begin
                rdValue[ten_ops_pkg::BS_RFAULT_BIT] = rfLatch;
                rdValue[ten_ops_pkg::BS_LINK_BIT]   = linkLatch;
            end
            ten_ops_pkg::EXT_STATUS: begin
                rdValue[ten_ops_pkg::ES_RFAULT_BIT] = rfLatch;
                rdValue[ten_ops_pkg::ES_LINK_BIT]   = linkLatch;
            end
            ten_ops_pkg::OPERATIONS: begin
                rdValue[ten_ops_pkg::POL_REV_BIT]   = polLatch;
                rdValue[ten_ops_pkg::JAB_INH_BIT]   = jabInh;
                rdValue[ten_ops_pkg::APOL_INH_BIT]  = apolInh;
                rdValue[ten_ops_pkg::SQE_INH_BIT]   = sqeInh;
                rdValue[ten_ops_pkg::LLOSS_INH_BIT] = llossInh;
                rdValue[ten_ops_pkg::SQL_INH_BIT]   = sqlInh;
            end
            default: begin
                rdValue = '0;
            end
        endcase
    end

    // Read data stand one cycle, else zero
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            regRdData <= '0;
        end else if (regRd) begin
            regRdData <= rdValue;
        end else begin
            regRdData <= '0;
        end
    end
endmodule : ten_mbps_ops_ctrl

// *** testbench/ten_ops_properties.sv ***
// Purpose: port-level assertions for the operations control block
// Assumes: one clock, asynchronous active-low reset
// Notes:   control bits are shadowed from register writes
`timescale 1ns/1ns
module ten_ops_properties (
    input wire logic        clk,           // Clock
    input wire logic        rst_b,         // Reset, active low
    input wire logic [4:0]  regAddr,       // Register number
    input wire logic [15:0] regWrData,     // Write data
    input wire logic        regWr,         // Write strobe
    input wire logic        regRd,         // Read strobe
    input wire logic [15:0] regRdData,     // Read data
    input wire logic        txEnable,      // Transmit enable
    input wire logic        fullDuplex,    // Full-duplex mode
    input wire logic        repeaterMode,  // Repeater mode
    input wire logic        collisionOut,  // Collision
    input wire logic        jabberOut,     // Jabber
    input wire logic        linkUp,        // Link passed
    input wire logic        polarityFixEn  // Correction applied
);
    logic [5:0] ctrl_reg;    // Control bits as last written
    logic [5:0] colRun_reg;  // Length of current collision pulse
    logic       modeOff;     // A mode that suppresses the SQE test
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    // Shadow of control bits, not visible at ports
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) ctrl_reg <= 6'h00;
        else if (regWr && regAddr == ten_ops_pkg::OPERATIONS) ctrl_reg <= regWrData[5:0] & 6'h2F;
    end
    // Saturates so a stuck pulse cannot wrap
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) colRun_reg <= 6'h00;
        else if (!collisionOut) colRun_reg <= 6'h00;
        else if (colRun_reg != 6'h3F) colRun_reg <= colRun_reg + 6'h01;
    end
    assign modeOff = fullDuplex | repeaterMode;
    chk_rsv_read_zero: assert property (
        $past(regRd) && $past(regAddr) == ten_ops_pkg::OPERATIONS |-> (regRdData & 16'hBFD0) == 16'h0000)
        else $error("reserved operations bits read nonzero");
    chk_idle_rdata: assert property (!$past(regRd) |-> regRdData == 16'h0000)
        else $error("read data outside read cycle");
    chk_ctrl_readback: assert property (
        $past(regRd) && $past(regAddr) == ten_ops_pkg::OPERATIONS |-> regRdData[5:0] == $past(ctrl_reg))
        else $error("control bits read back wrong");
    chk_link_forced: assert property (ctrl_reg[1] |=> linkUp)
        else $error("link not forced to pass");
    chk_sqe_after_tx: assert property (
        $fell(txEnable) && !ctrl_reg[2] && !modeOff |-> ##[15:30] collisionOut)
        else $error("no SQE pulse after transmit");
    chk_sqe_mode_kill: assert property (
        modeOff [*3] |-> !collisionOut)
        else $error("SQE pulse in suppressing mode");
    chk_sqe_inh_kill: assert property (
        ctrl_reg[2] [*3] |-> !collisionOut)
        else $error("SQE pulse while inhibited");
    chk_sqe_width: assert property (int'(colRun_reg) <= ten_ops_pkg::SQE_WIDTH_CYC)
        else $error("SQE pulse too long");
    chk_jab_inhibit: assert property (
        ctrl_reg[5] [*3] |-> !jabberOut)
        else $error("jabber while inhibited");
    chk_pol_inhibit: assert property (
        ctrl_reg[3] [*3] |-> !polarityFixEn)
        else $error("correction while inhibited");
    cov_sqe: cover property ($rose(collisionOut));
    cov_jab: cover property ($rose(jabberOut));
    cov_pol: cover property ($rose(polarityFixEn));
endmodule : ten_ops_properties

// *** testbench/mgmt_station.sv ***
// Purpose: management station model on the register port
// Assumes: one-cycle strobes, read data in the following cycle
// Notes:   idle bus shows the inverse of the last value
`timescale 1ns/1ns
module mgmt_station (
    input  wire logic        clk,        // Clock
    output logic      [4:0]  regAddr,    // Register number
    output logic      [15:0] regWrData,  // Write data
    output logic             regWr,      // Write strobe
    output logic             regRd,      // Read strobe
    input  wire logic [15:0] regRdData   // Read data
);
    // Quiet bus at time zero
    initial begin
        regAddr = 5'h00;
        regWrData = 16'h0000;
        regWr = 1'b0;
        regRd = 1'b0;
    end
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge clk);
        regWr <= 1'b1;
        regAddr <= a;
        // Reserved bits at defaults
        regWrData <= (a == ten_ops_pkg::OPERATIONS) ? ((d & 16'h002F) | 16'h0010) : d;
        @(posedge clk);
        regWr <= 1'b0;
        regAddr <= ~a;
        regWrData <= ~d;
    endtask : wr
    task automatic rd(input logic [4:0] a, output logic [15:0] d);
        @(posedge clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRd <= 1'b0;
        regAddr <= ~a;
        @(posedge clk);
        d = regRdData;
    endtask : rd
endmodule : mgmt_station

// *** testbench/ten_mbps_operations_control_tb_top.sv ***
// Purpose: self-checking bench for the operations control block
// Assumes: 20 MHz clock, shortened jabber and link-loss counts
// Notes:   register cases run from a table, the rest by hand
`timescale 1ns/1ns
module ten_mbps_operations_control_tb_top;
    localparam int         JAB = 50;
    localparam int         LOSS = 200;
    localparam logic [4:0] OPS = ten_ops_pkg::OPERATIONS;
    logic        clk = 1'b0;
    logic        rst_b = 1'b0;
    logic [4:0]  regAddr;
    logic [15:0] regWrData;
    logic        regWr;
    logic        regRd;
    logic [15:0] regRdData;
    logic        rxPairPos = 1'b0;
    logic        rxPairNeg = 1'b0;
    logic        txEnable = 1'b0;
    logic        fullDuplex = 1'b0;
    logic        repeaterMode = 1'b0;
    logic        remoteFaultIn = 1'b0;
    logic        rxData, rxActive, collisionOut, jabberOut, linkUp, polarityFixEn;
    logic [15:0] d;
    logic        b, lk;
    int          w, numErrors = 0, samplesChecked = 0, cycles = 0;
    // Write value beside read-back value
    logic [31:0] rows[5] = '{32'h0020_0020, 32'h000D_000D, 32'hFFFF_002F, 32'h0012_0002, 32'h0};
    ten_mbps_ops_ctrl #(.JABBER_CYCLES(JAB), .LINK_LOSS_CYCLES(LOSS)) uut (
        .clk, .rst_b, .regAddr, .regWrData, .regWr, .regRd, .regRdData, .rxPairPos, .rxPairNeg,
        .txEnable, .fullDuplex, .repeaterMode, .remoteFaultIn, .rxData, .rxActive,
        .collisionOut, .jabberOut, .linkUp, .polarityFixEn);
    mgmt_station stn (.clk, .regAddr, .regWrData, .regWr, .regRd, .regRdData);
    always #25 clk = ~clk;
    task automatic chk16(input string n, input logic [15:0] e, input logic [15:0] g);
        samplesChecked++;
        if (g !== e) begin
            numErrors++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask : chk16
    task automatic chk1(input string n, input logic e, input logic g);
        samplesChecked++;
        if (g !== e) begin
            numErrors++;
            $display("BAD %s expected %b seen %b", n, e, g);
        end
    endtask : chk1
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick
    // Receive burst, outputs sampled at its end
    task automatic pulse(input logic p, input logic n, output logic rx, output logic lkUp);
        @(posedge clk);
        rxPairPos <= p;
        rxPairNeg <= n;
        tick(10);
        rx = rxData;
        lkUp = linkUp;
        rxPairPos <= 1'b0;
        rxPairNeg <= 1'b0;
        tick(10);
    endtask : pulse
    // Packet, then count collision cycles
    task automatic txPacket(input int len, output int wid, output logic jab);
        wid = 0;
        @(posedge clk);
        txEnable <= 1'b1;
        tick(len);
        jab = jabberOut;
        txEnable <= 1'b0;
        repeat (60) begin
            @(posedge clk);
            if (collisionOut === 1'b1) wid++;
        end
    endtask : txPacket
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", samplesChecked, numErrors);
        if (numErrors == 0 && samplesChecked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : report_and_stop
    // Hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 8000) begin
            numErrors++;
            $display("BAD run length expected under 8000 seen 8000");
            report_and_stop();
        end
    end
    initial begin
        tick(20);
        rst_b <= 1'b1;
        stn.rd(OPS, d);
        chk16("ops after reset", 16'h0000, d);
        chk1("link after reset", 1'b0, linkUp);
        $display("end reset test");
        for (int i = 0; i < 5; i++) begin
            stn.wr(OPS, rows[i][31:16]);
            stn.rd(OPS, d);
            chk16("ops readback", rows[i][15:0], d);
        end
        stn.wr(5'h1F, 16'hFFFF);
        stn.rd(5'h1F, d);
        chk16("unmapped read", 16'h0000, d);
        stn.rd(OPS, d);
        chk16("ops untouched", 16'h0000, d);
        $display("end register table");
        // Normal, full duplex, repeater, inhibited
        for (int m = 0; m < 4; m++) begin
            fullDuplex <= (m == 1);
            repeaterMode <= (m == 2);
            stn.wr(OPS, (m == 3) ? 16'h0004 : 16'h0000);
            txPacket(10, w, b);
            chk16("sqe width", (m == 0) ? 16'(ten_ops_pkg::SQE_WIDTH_CYC) : 16'h0, 16'(w));
            stn.rd(OPS, d);
            chk16("sqe control kept", (m == 3) ? 16'h0004 : 16'h0000, d);
        end
        $display("end sqe test");
        stn.wr(OPS, 16'h0020);
        txPacket(JAB + 20, w, b);
        chk1("jabber inhibited", 1'b0, b);
        stn.wr(OPS, 16'h0000);
        txPacket(JAB + 20, w, b);
        chk1("jabber seen", 1'b1, b);
        $display("end jabber test");
        stn.wr(OPS, 16'h0002);
        tick(2);
        chk1("link forced", 1'b1, linkUp);
        for (int s = 0; s < 2; s++) begin
            stn.wr(OPS, 16'(s));
            tick(LOSS + 50);
            chk1("link dropped", 1'b0, linkUp);
            pulse(1'b1, 1'b0, b, lk);
            chk1("link in activity", (s == 0), lk);
            chk1("link after idle", 1'b1, linkUp);
        end
        $display("end link test");
        stn.rd(ten_ops_pkg::BASIC_STATUS, d);
        stn.rd(ten_ops_pkg::EXT_STATUS, d);
        chk16("ext link copy", 16'h0001, d & 16'h0003);
        remoteFaultIn <= 1'b1;
        tick(3);
        stn.rd(ten_ops_pkg::EXT_STATUS, d);
        chk16("ext fault copy", 16'h0003, d & 16'h0003);
        stn.rd(ten_ops_pkg::BASIC_STATUS, d);
        chk16("basic fault", 16'h0014, d & 16'h0014);
        remoteFaultIn <= 1'b0;
        tick(3);
        stn.rd(ten_ops_pkg::EXT_STATUS, d);
        chk16("fault latched", 16'h0002, d & 16'h0002);
        stn.rd(ten_ops_pkg::BASIC_STATUS, d);
        chk16("fault cleared", 16'h0000, d & 16'h0010);
        $display("end status test");
        stn.wr(OPS, 16'h0000);
        pulse(1'b0, 1'b1, b, lk);
        chk1("rx data corrected", 1'b1, b);
        chk1("rx idle after burst", 1'b0, rxActive);
        chk1("fix enabled", 1'b1, polarityFixEn);
        pulse(1'b1, 1'b0, b, lk);
        chk1("fix dropped", 1'b0, polarityFixEn);
        stn.rd(OPS, d);
        chk16("polarity latched", 16'h4000, d);
        stn.rd(OPS, d);
        chk16("polarity cleared", 16'h0000, d);
        stn.wr(OPS, 16'h0008);
        pulse(1'b0, 1'b1, b, lk);
        chk1("rx data raw", 1'b0, b);
        chk1("fix inhibited", 1'b0, polarityFixEn);
        stn.rd(OPS, d);
        chk16("polarity flag inhibited", 16'h4008, d);
        $display("end polarity test");
        report_and_stop();
    end
endmodule : ten_mbps_operations_control_tb_top
bind ten_mbps_ops_ctrl ten_ops_properties chk (.clk, .rst_b, .regAddr, .regWrData, .regWr,
    .regRd, .regRdData, .txEnable, .fullDuplex, .repeaterMode, .collisionOut, .jabberOut,
    .linkUp, .polarityFixEn);
